// ---- shared/wdt_defs.svh ----
// register indices, field positions, key values and reset values of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define WDT_IDX_CTRL 8'h3c
`define WDT_IDX_TEST_A 8'h3d
`define WDT_IDX_TEST_B 8'h3e
`define WDT_IDX_ARM 8'h3f
`define WDT_IDX_TEST_C 8'h40
`define WDT_IDX_STAT 8'h41
`define WDT_IDX_MASK 8'h42
`define WDT_IDX_CFG 8'h43

// ---------------------------------------------------------------
// control and configuration register fields
// ---------------------------------------------------------------
`define WDT_CTRL_WIN 7
`define WDT_CTRL_DBG 6
`define WDT_CTRL_WMASK 5
`define WDT_CTRL_RATE_HI 2
`define WDT_CTRL_RATE_LO 0
`define WDT_CFG_CLKSEL 0

// ---------------------------------------------------------------
// rates, keys, events, reset values
// ---------------------------------------------------------------
`define WDT_RATE_OFF 3'h0
`define WDT_RATE_MAX 3'h7
`define WDT_LOG2_R1 5'h0e
`define WDT_LOG2_R2 5'h10
`define WDT_LOG2_R3 5'h12
`define WDT_LOG2_R4 5'h14
`define WDT_LOG2_R5 5'h16
`define WDT_LOG2_R6 5'h17
`define WDT_LOG2_MAX 5'h18
`define WDT_KEY_FIRST 8'h55
`define WDT_KEY_SECOND 8'haa
`define WDT_EV_N 4
`define WDT_RST_RATE 3'h0
`define WDT_RST_WIN 1'h0
`define WDT_RST_BYTE 8'h00
`define WDT_RST_EV 4'h0

`endif

// ---- shared/wdt_pkg.sv ----
// types shared by the watchdog control and arm block
`default_nettype none
package wdt_pkg;
`include "wdt_defs.svh"

    typedef struct packed {
        logic window;
        logic dbg_stop;
        logic [2:0] rate;
    } ctrl_t;

    typedef struct packed {
        logic restart;
        logic early;
        logic bad_value;
        logic timeout;
    } wdt_events_t;

    typedef enum logic [0:0] {
        ARM_IDLE,
        ARM_SEEN
    } arm_state_t;

endpackage : wdt_pkg

`default_nettype wire

// ---- rtl/wdt_period_counter.sv ----
// timeout counter with selectable power-of-two period and window flag
`timescale 1ns/1ps
`default_nettype none

module wdt_period_counter #(
    parameter int CNT_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [4:0] log2_i,
    output logic expired_o,
    output logic win_open_o,
    output logic [CNT_W-1:0] count_o
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic expired_q;
    logic [CNT_W:0] one_sh;
    logic [CNT_W:0] mask_full;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] win_start;
    logic at_end;

    if (CNT_W < 2) begin : g_bad_width
        $error("wdt_period_counter: CNT_W too small");
    end

    // ---------------------------------------------------------------
    // period end and start of the last quarter
    // ---------------------------------------------------------------
    assign one_sh = (CNT_W + 1)'(1) << log2_i;
    assign mask_full = one_sh - (CNT_W + 1)'(1);
    assign last = mask_full[CNT_W-1:0];
    assign win_start = last ^ (last >> 2);
    assign at_end = count_q >= last;
    assign count_d = restart_i ? '0 : (tick_i ? (at_end ? '0 : count_q + CNT_W'(1)) : count_q);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= '0;
            expired_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_q <= tick_i & ~restart_i & at_end;
        end
    end

    assign expired_o = expired_q;
    assign win_open_o = count_q >= win_start;
    assign count_o = count_q;

endmodule : wdt_period_counter

`default_nettype wire

// ---- rtl/wdt_ctrl_arm.sv ----
// watchdog control, arm sequence, factory test registers and wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_ctrl_arm import wdt_pkg::*; #(
    parameter int ADR_W = 10,
    parameter int CNT_W = 24,
    parameter int PERIOD_SHRINK = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic special_mode_i,
    input wire logic debug_active_i,
    input wire logic ref_tick_i,
    input wire logic osc_tick_i,
    output logic wdt_reset_o,
    output logic irq_o
);

    if (ADR_W < 10 || CNT_W < 24 || CNT_W > 30 || PERIOD_SHRINK < 0 || PERIOD_SHRINK > 12)
    begin : g_bad_param
        $error("wdt_ctrl_arm: unsupported parameter value");
    end

    localparam logic [4:0] SHRINK5 = 5'(PERIOD_SHRINK);
    localparam int N_TEST = 3;
    localparam logic [7:0] TEST_IDX [N_TEST] = '{`WDT_IDX_TEST_A, `WDT_IDX_TEST_B,
                                                 `WDT_IDX_TEST_C};

    function automatic logic [4:0] rate_log2(input logic [2:0] rate);
        logic [4:0] l2;
        l2 = `WDT_LOG2_MAX;
        case (rate)
            3'h1: l2 = `WDT_LOG2_R1;
            3'h2: l2 = `WDT_LOG2_R2;
            3'h3: l2 = `WDT_LOG2_R3;
            3'h4: l2 = `WDT_LOG2_R4;
            3'h5: l2 = `WDT_LOG2_R5;
            3'h6: l2 = `WDT_LOG2_R6;
            default: l2 = `WDT_LOG2_MAX;
        endcase
        return l2;
    endfunction : rate_log2

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    wire wr = wb_req & wb_we_i & wb_sel_i[0];
    wire [7:0] idx = wb_adr_i[9:2];
    wire [7:0] wdat = wb_dat_i[7:0];
    wire hit_ctrl = idx == `WDT_IDX_CTRL;
    wire hit_arm = idx == `WDT_IDX_ARM;
    wire hit_stat = idx == `WDT_IDX_STAT;
    wire hit_mask = idx == `WDT_IDX_MASK;
    wire hit_cfg = idx == `WDT_IDX_CFG;

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    ctrl_t ctrl_q;
    ctrl_t ctrl_d;
    logic once_used_q;
    logic clksel_q;
    wire ctrl_wr = wr & hit_ctrl;
    wire wmask = wdat[`WDT_CTRL_WMASK];
    wire [2:0] wrate = wdat[`WDT_CTRL_RATE_HI:`WDT_CTRL_RATE_LO];
    wire wwin = wdat[`WDT_CTRL_WIN];
    wire fields_take = ctrl_wr & ~wmask & (special_mode_i | ~once_used_q);
    wire once_d = once_used_q | (ctrl_wr & ~wmask & ~special_mode_i);
    wire dbg_d = ~ctrl_wr ? ctrl_q.dbg_stop :
                 (special_mode_i ? wdat[`WDT_CTRL_DBG] : (ctrl_q.dbg_stop | wdat[`WDT_CTRL_DBG]));
    wire [2:0] rate_new = special_mode_i ? wrate
                          : ((wrate != `WDT_RATE_OFF) ? wrate : ctrl_q.rate);
    wire win_new = special_mode_i ? wwin : (ctrl_q.window | wwin);
    assign ctrl_d.rate = fields_take ? rate_new : ctrl_q.rate;
    assign ctrl_d.window = fields_take ? win_new : ctrl_q.window;
    assign ctrl_d.dbg_stop = dbg_d;

    // restart sources
    wire dbg_rise = ~ctrl_q.dbg_stop & dbg_d;
    wire field_restart = fields_take & ((wrate != `WDT_RATE_OFF) | wwin);
    wire special_restart = ctrl_wr & special_mode_i;
    wire cfg_wr = wr & hit_cfg;
    wire clksel_chg = cfg_wr & (wdat[`WDT_CFG_CLKSEL] != clksel_q);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= '{window: `WDT_RST_WIN, dbg_stop: 1'b0, rate: `WDT_RST_RATE};
            once_used_q <= 1'b0;
            clksel_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            once_used_q <= once_d;
            clksel_q <= cfg_wr ? wdat[`WDT_CFG_CLKSEL] : clksel_q;
        end
    end

    // ---------------------------------------------------------------
    // effective mode and watchdog clock
    // ---------------------------------------------------------------
    wire enabled = ctrl_q.rate != `WDT_RATE_OFF;
    wire override = enabled & debug_active_i & ~ctrl_q.dbg_stop & special_mode_i;
    wire [2:0] eff_rate = override ? `WDT_RATE_MAX : ctrl_q.rate;
    wire eff_window = ~override & ctrl_q.window;
    wire [4:0] cnt_log2 = rate_log2(eff_rate) - SHRINK5;
    wire halt = debug_active_i & ctrl_q.dbg_stop;
    wire wd_tick = clksel_q ? osc_tick_i : ref_tick_i;
    wire cnt_tick = wd_tick & enabled & ~halt;

    // ---------------------------------------------------------------
    // arm sequence
    // ---------------------------------------------------------------
    arm_state_t arm_st_q;
    arm_state_t arm_st_d;
    wire cnt_expired;
    wire win_open;
    wire [CNT_W-1:0] cnt_val;
    wire arm_wr = wr & hit_arm & enabled;
    wire early = arm_wr & eff_window & ~win_open;
    wire key1 = wdat == `WDT_KEY_FIRST;
    wire key2 = wdat == `WDT_KEY_SECOND;
    wire bad_val = arm_wr & ~early & ~key1 & ~key2;
    wire arm_done = arm_wr & ~early & key2 & (arm_st_q == ARM_SEEN);
    wire reset_req = cnt_expired | bad_val | early;
    wire restart = field_restart | special_restart | dbg_rise | clksel_chg | arm_done;
    wire cnt_restart = restart | reset_req | ~enabled;

    always_comb begin
        arm_st_d = arm_st_q;
        case (arm_st_q)
            ARM_IDLE: begin
                if (arm_wr & ~early & key1) begin
                    arm_st_d = ARM_SEEN;
                end
            end
            ARM_SEEN: begin
                arm_st_d = ARM_SEEN;
            end
            default: begin
                arm_st_d = ARM_IDLE;
            end
        endcase
        if (restart | reset_req) begin
            arm_st_d = ARM_IDLE;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_st_q <= ARM_IDLE;
        end else begin
            arm_st_q <= arm_st_d;
        end
    end

    wdt_period_counter #(
        .CNT_W(CNT_W)
    ) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(cnt_tick),
        .restart_i(cnt_restart),
        .log2_i(cnt_log2),
        .expired_o(cnt_expired),
        .win_open_o(win_open),
        .count_o(cnt_val)
    );

    // ---------------------------------------------------------------
    // factory test registers
    // ---------------------------------------------------------------
    logic [N_TEST-1:0][7:0] test_q;
    logic [N_TEST-1:0] hit_test;
    logic [7:0] test_rd;

    for (genvar i = 0; i < N_TEST; i++) begin : g_test
        assign hit_test[i] = idx == TEST_IDX[i];
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                test_q[i] <= `WDT_RST_BYTE;
            end else if (wr & hit_test[i] & special_mode_i) begin
                test_q[i] <= wdat;
            end
        end
    end

    always_comb begin
        test_rd = `WDT_RST_BYTE;
        for (int k = 0; k < N_TEST; k++) begin
            test_rd = test_rd | (hit_test[k] ? test_q[k] : `WDT_RST_BYTE);
        end
    end

    // ---------------------------------------------------------------
    // event status, mask and interrupt
    // ---------------------------------------------------------------
    wdt_events_t stat_q;
    wdt_events_t stat_d;
    wdt_events_t ev;
    logic [`WDT_EV_N-1:0] mask_q;
    logic irq_q;
    logic wdt_reset_q;
    wire [`WDT_EV_N-1:0] w1c = (wr & hit_stat) ? wdat[`WDT_EV_N-1:0] : `WDT_RST_EV;
    wire [`WDT_EV_N-1:0] mask_d = (wr & hit_mask) ? wdat[`WDT_EV_N-1:0] : mask_q;
    assign ev = '{restart: arm_done, early: early, bad_value: bad_val, timeout: cnt_expired};
    // set wins over a clear in the same cycle
    assign stat_d = ev | (stat_q & ~w1c);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= `WDT_RST_EV;
            mask_q <= `WDT_RST_EV;
            irq_q <= 1'b0;
            wdt_reset_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= |(stat_d & mask_d);
            wdt_reset_q <= reset_req;
        end
    end

    // ---------------------------------------------------------------
    // read data and acknowledge
    // ---------------------------------------------------------------
    wire [7:0] ctrl_rd = {ctrl_q.window, ctrl_q.dbg_stop, 3'h0, ctrl_q.rate};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_stat ? {4'h0, stat_q} :
                         hit_mask ? {4'h0, mask_q} :
                         hit_cfg ? {7'h00, clksel_q} :
                         test_rd; // arm and unmapped read zero

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= wb_req;
            wb_dat_q <= (wb_req & ~wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign irq_o = irq_q;
    assign wdt_reset_o = wdt_reset_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_mask_keeps_fields: assert property (
        (ctrl_wr & wmask) |=> ($stable(ctrl_q.rate) && $stable(ctrl_q.window)
                               && $stable(once_used_q)))
        else $error("masked control write changed fields");
    a_rate_write_enables: assert property (
        (fields_take & (wrate != `WDT_RATE_OFF)) |=> (enabled && cnt_val == '0))
        else $error("nonzero rate write did not start period");
    a_expiry_resets: assert property (
        cnt_expired |=> (wdt_reset_o && cnt_val == '0))
        else $error("expiry did not raise reset");
    a_debug_override: assert property (
        (enabled & debug_active_i & ~ctrl_q.dbg_stop & special_mode_i)
        |-> (cnt_log2 == `WDT_LOG2_MAX - SHRINK5 && !eff_window))
        else $error("debug override not applied");
    a_rate_one_decode: assert property (
        (ctrl_q.rate == 3'h1 && !override) |-> cnt_log2 == `WDT_LOG2_R1 - SHRINK5)
        else $error("rate decode wrong");
    a_clock_gates_count: assert property (
        (!(clksel_q ? osc_tick_i : ref_tick_i) && !cnt_restart) |=> $stable(cnt_val))
        else $error("counter moved without selected clock");
    a_disabled_arm_noop: assert property (
        (wr & hit_arm & ~enabled) |=> (!wdt_reset_o && arm_st_q == ARM_IDLE))
        else $error("arm write acted while disabled");
    a_arm_reads_zero: assert property (
        (wb_req & ~wb_we_i & hit_arm) |=> wb_dat_o == 32'h0000_0000)
        else $error("arm register read nonzero");
    a_bad_key_resets: assert property (
        (wr & hit_arm & enabled & ~key1 & ~key2) |=> wdt_reset_o)
        else $error("bad arm value did not reset");
    a_key_pair_restart: assert property (
        (wr & hit_arm & key2 & arm_st_q == ARM_SEEN & ~early) |=> (cnt_val == '0 && !wdt_reset_o))
        else $error("key pair did not restart");
    a_early_write_resets: assert property (
        (wr & hit_arm & enabled & eff_window & ~win_open) |=> wdt_reset_o)
        else $error("early arm write did not reset");
    a_test_write_normal: assert property (
        (wr & hit_test[0] & ~special_mode_i) |=> $stable(test_q[0]))
        else $error("test register written in normal mode");
    a_write_once_normal: assert property (
        (ctrl_wr & ~special_mode_i & once_used_q) |=> ($stable(ctrl_q.rate)
                                                         && $stable(ctrl_q.window)))
        else $error("second normal control write took effect");
    a_special_restart: assert property (
        (ctrl_wr & special_mode_i) |=> cnt_val == '0)
        else $error("special control write did not restart");
    a_seen_cleared: assert property (
        (restart | reset_req) |=> arm_st_q == ARM_IDLE)
        else $error("seen state not cleared");

    c_arm_pair: cover property (arm_done);
    c_window_violation: cover property (early);
    c_expiry: cover property (cnt_expired);
    c_override: cover property (override ##1 cnt_tick);
    c_debug_halt: cover property (halt & wd_tick & enabled);

endmodule : wdt_ctrl_arm

`default_nettype wire

// ---- tb/wdt_ctrl_arm_tb_top.sv ----
// self-checking testbench of the watchdog control and arm block
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_ctrl_arm_tb_top;

    // ---------------------------------------------------------------
    // signals and design instance
    // ---------------------------------------------------------------
    localparam int SHR = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h1;
    logic [31:0] dat = 32'h0;
    logic special = 1'b0;
    logic dbg = 1'b0;
    logic ref_tick = 1'b1;
    logic osc_tick = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic wdt_rst;
    logic irq;
    int failures = 0;
    int checks = 0;
    int pulses = 0;
    int lg[7] = '{14, 16, 18, 20, 22, 23, 24};

    wdt_ctrl_arm #(.PERIOD_SHRINK(SHR)) i_wdt_ctrl_arm (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .special_mode_i(special), .debug_active_i(dbg), .ref_tick_i(ref_tick),
        .osc_tick_i(osc_tick), .wdt_reset_o(wdt_rst), .irq_o(irq)
    );

    always #4 clk_i = ~clk_i;

    // reset requests are single-cycle pulses, counted mid-cycle
    always @(negedge clk_i) begin
        if (wdt_rst === 1'b1) begin
            pulses++;
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi, input int n);
        checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
    endtask : chk_rng

    // one classic cycle; entered and left just after a rising edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(nm, e, q);
    endtask : rd

    task automatic measure(output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (wdt_rst !== 1'b1 && n < 20000);
        @(posedge clk_i);
    endtask : measure

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset

    initial begin
        repeat (90000) @(posedge clk_i);
        failures++;
        complete_run();
    end

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        int n;
        int p0;
        do_reset();
        rd("ctrl", `WDT_IDX_CTRL, 32'h0);
        rd("arm", `WDT_IDX_ARM, 32'h0);
        rd("status", `WDT_IDX_STAT, 32'h0);
        rd("unmapped", 8'h10, 32'h0);
        wr(`WDT_IDX_TEST_A, 8'h5a);
        rd("test_a", `WDT_IDX_TEST_A, 32'h0);
        special <= 1'b1;
        wr(`WDT_IDX_TEST_C, 8'h5a);
        special <= 1'b0;
        rd("test_c", `WDT_IDX_TEST_C, 32'h5a);
        wr(`WDT_IDX_ARM, 8'h12);
        repeat (40) @(posedge clk_i);
        chk("pulses", 32'h0, 32'(pulses));
        wr(`WDT_IDX_CTRL, 8'h21);
        rd("ctrl", `WDT_IDX_CTRL, 32'h0);
        wr(`WDT_IDX_CTRL, 8'h01);
        measure(n);
        chk_rng("rate1", 14, 20, n);
        rd("status", `WDT_IDX_STAT, 32'h1);
        wr(`WDT_IDX_CTRL, 8'h07);
        rd("ctrl", `WDT_IDX_CTRL, 32'h1);

        do_reset();
        wr(`WDT_IDX_MASK, 8'h02);
        wr(`WDT_IDX_CTRL, 8'h07);
        p0 = pulses;
        wr(`WDT_IDX_ARM, 8'h33);
        chk("bad arm", 32'h1, 32'(pulses - p0));
        rd("status", `WDT_IDX_STAT, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`WDT_IDX_STAT, 8'h02);
        rd("status", `WDT_IDX_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`WDT_IDX_MASK, 8'h00);
        wr(`WDT_IDX_ARM, 8'h44);
        rd("status", `WDT_IDX_STAT, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});

        do_reset();
        wr(`WDT_IDX_CTRL, 8'h02);
        p0 = pulses;
        for (int i = 0; i < 5; i++) begin
            repeat (30) @(posedge clk_i);
            wr(`WDT_IDX_ARM, 8'h55);
            wr(`WDT_IDX_ARM, 8'h55);
            wr(`WDT_IDX_ARM, 8'haa);
        end
        chk("arm restart", 32'h0, 32'(pulses - p0));
        rd("status", `WDT_IDX_STAT, 32'h8);
        wr(`WDT_IDX_ARM, 8'h55);
        wr(`WDT_IDX_ARM, 8'haa);
        repeat (40) @(posedge clk_i);
        wr(`WDT_IDX_ARM, 8'haa);
        measure(n);
        chk_rng("seen clear", 12, 26, n);

        do_reset();
        wr(`WDT_IDX_CTRL, 8'h82);
        p0 = pulses;
        wr(`WDT_IDX_ARM, 8'h55);
        repeat (2) @(posedge clk_i);
        chk("early", 32'h1, 32'(pulses - p0));
        repeat (48) @(posedge clk_i);
        wr(`WDT_IDX_ARM, 8'h55);
        wr(`WDT_IDX_ARM, 8'haa);
        chk("late", 32'h1, 32'(pulses - p0));
        rd("status", `WDT_IDX_STAT, 32'hc);

        do_reset();
        special <= 1'b1;
        wr(`WDT_IDX_CTRL, 8'h02);
        p0 = pulses;
        for (int i = 0; i < 6; i++) begin
            repeat (40) @(posedge clk_i);
            wr(`WDT_IDX_CTRL, 8'h20);
        end
        chk("ctrl restart", 32'h0, 32'(pulses - p0));
        for (int r = 1; r < 8; r++) begin
            wr(`WDT_IDX_CTRL, 8'(r));
            measure(n);
            chk_rng("rate", (1 << (lg[r-1] - SHR)) - 2, (1 << (lg[r-1] - SHR)) + 4, n);
        end
        dbg <= 1'b1;
        wr(`WDT_IDX_CTRL, 8'h81);
        p0 = pulses;
        wr(`WDT_IDX_ARM, 8'h55);
        measure(n);
        chk("no window", 32'h0, 32'(pulses - p0 - 1));
        chk_rng("override", 16376, 16392, n);
        wr(`WDT_IDX_CTRL, 8'h41);
        p0 = pulses;
        repeat (100) @(posedge clk_i);
        chk("debug halt", 32'h0, 32'(pulses - p0));
        dbg <= 1'b0;
        wr(`WDT_IDX_CFG, 8'h01);
        wr(`WDT_IDX_CTRL, 8'h01);
        p0 = pulses;
        repeat (100) @(posedge clk_i);
        chk("osc idle", 32'h0, 32'(pulses - p0));
        osc_tick <= 1'b1;
        measure(n);
        chk_rng("osc", 14, 20, n);
        complete_run();
    end

endmodule : wdt_ctrl_arm_tb_top

`default_nettype wire
